/* design/mer_report_framer.sv */
// Report framer toward the core pseudowire and missed-burst handler.
// Assumes all inputs come from logic on clk; pseudowire sink may stall.
`timescale 1ns/1ps
`default_nettype none

module mer_report_framer (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          reset,
   // AXI4-Lite slave
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Report descriptor, sections and values
   input  wire logic          rpt_valid,
   input  wire mer_pkg::rpt_s rpt,
   output logic               rpt_ready,
   input  wire logic          sec_valid,
   input  wire mer_pkg::sec_s sec,
   output logic               sec_ready,
   input  wire logic          mer_valid,
   input  wire logic [7:0]    mer_byte,
   output logic               mer_ready,
   // Vendor units
   input  wire logic          unit_valid,
   input  wire mer_pkg::pw_s  unit,
   output logic               unit_ready,
   // Pseudowire output
   output logic               pw_valid,
   output mer_pkg::pw_s       pw,
   input  wire logic          pw_ready,
   // Scheduled intervals
   input  wire logic          slot_start,
   input  wire mer_pkg::slot_s slot_info,
   input  wire logic          preamble,
   input  wire logic          slot_end,
   // Radio samples
   input  wire logic          rf_valid,
   input  wire logic [31:0]   rf_data,
   output logic               rf_out_valid,
   output logic [31:0]        rf_out_data,
   // Core messages and interrupt
   output logic               msg_valid,
   output mer_pkg::slot_s     msg,
   input  wire logic          msg_ready,
   output logic               irq
);
   import mer_pkg::*;

   typedef enum {S_IDLE, S_HDR, S_SEC, S_MER, S_TRL, S_UNIT} state_e;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic class_s classify(input slot_s s);
      class_s c;
      logic   grant;
      c.row = NO_ROW;
      grant = 1'b0;
      case (s.interval_usage_code)
         4'h1: c.row = (s.service_identifier == BCAST_SID) ? 4'h0 : 4'h1;
         4'h2: c.row = 4'h2;
         4'h3: c.row = (s.service_identifier == BCAST_SID) ? 4'h3 : 4'h4;
         4'h4: c.row = 4'h5;
         4'h5: begin c.row = 4'h6; grant = 1'b1; end
         4'h6: begin c.row = 4'h7; grant = 1'b1; end
         4'h9: begin c.row = 4'h8; grant = 1'b1; end
         4'ha: begin c.row = 4'h9; grant = 1'b1; end
         4'hb: begin c.row = 4'ha; grant = 1'b1; end
         default: c.row = NO_ROW;
      endcase
      // Undefined energy code 11 is ignored like a reserved usage code
      if (c.row == NO_ROW || s.energy == 2'h3)
         c.act = ACT_NONE;
      else if (grant && s.energy == EN_LOW)
         c.act = ACT_MSG;
      else
         c.act = ACT_COUNT;
      return c;
   endfunction

   // Energy code to counter slot: 0 low, 1 medium, 2 high, as software selects it
   function automatic logic [1:0] energy_idx(input logic [1:0] en);
      return (en == EN_LOW) ? 2'h0 : (en == EN_MED) ? 2'h1 : 2'h2;
   endfunction

   function automatic logic [7:0] cnt_index(input logic [1:0] ch, input logic [3:0] row, input logic [1:0] e);
      return {6'h0, ch} * CNT_PER_CH + {4'h0, row} * EN_SLOTS + {6'h0, e};
   endfunction

   function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] i, input logic [7:0] b);
      logic [31:0] r;
      r = w;
      r[8*(3-i) +: 8] = b; // First value goes in the top byte
      return r;
   endfunction

   function automatic logic [31:0] strb(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (s[i]) r[8*i +: 8] = n[8*i +: 8];
      return r;
   endfunction

   // ----------------------------------------
   // Framer state machine
   // ----------------------------------------
   state_e      state, next_state;
   logic [7:0]  sec_left, next_sec_left;
   logic [12:0] rem, next_rem;
   logic [1:0]  idx, next_idx;
   logic [31:0] acc, next_acc;
   logic [7:0]  trl_pwr, trl_mer;
   logic        next_pw_valid, done_ev;
   pw_s         next_pw;
   logic [2:0]  ctrl;
   logic        take_rpt, take_sec, take_mer, take_unit;
   logic [31:0] word;

   assign take_rpt  = rpt_valid && rpt_ready;
   assign take_sec  = sec_valid && sec_ready;
   assign take_mer  = mer_valid && mer_ready;
   assign take_unit = unit_valid && unit_ready;

   always_comb
   begin
      next_state    = state;
      next_sec_left = sec_left;
      next_rem      = rem;
      next_idx      = idx;
      next_acc      = acc;
      next_pw       = pw;
      next_pw_valid = pw_valid && !pw_ready;
      done_ev       = 1'b0;
      word          = put_byte(acc, idx, mer_byte);
      case (state)
         S_IDLE:
            if (rpt_valid) next_state = S_HDR;
            else if (unit_valid) next_state = S_UNIT;
         S_HDR:
            if (take_rpt)
            begin
               next_pw       = '{{ctrl[1:0], 6'h0, 16'h0, rpt.sections}, 1'b0, KIND_MER};
               next_pw_valid = 1'b1;
               next_sec_left = rpt.sections;
               next_state    = (rpt.sections == 8'h0) ? S_TRL : S_SEC;
            end
         S_SEC:
            if (take_sec)
            begin
               next_pw       = '{{4'h0, sec.lowest, 4'h0, sec.highest}, 1'b0, KIND_MER};
               next_pw_valid = 1'b1;
               next_idx      = 2'h0;
               next_acc      = 32'h0;
               // An inverted range carries no values
               next_rem      = (sec.highest >= sec.lowest) ? {1'b0, sec.highest - sec.lowest} + 13'h1 : 13'h0;
               if (next_rem != 13'h0)
                  next_state = S_MER;
               else
               begin
                  next_sec_left = sec_left - 8'h1;
                  next_state    = (sec_left == 8'h1) ? S_TRL : S_SEC;
               end
            end
         S_MER:
            if (take_mer)
            begin
               next_rem = rem - 13'h1;
               next_idx = idx + 2'h1;
               next_acc = word;
               if (idx == 2'h3 || rem == 13'h1)
               begin
                  next_pw       = '{word, 1'b0, KIND_MER};
                  next_pw_valid = 1'b1;
                  next_acc      = 32'h0;
                  next_idx      = 2'h0;
               end
               if (rem == 13'h1)
               begin
                  next_sec_left = sec_left - 8'h1;
                  next_state    = (sec_left == 8'h1) ? S_TRL : S_SEC;
               end
            end
         S_TRL:
            if (!next_pw_valid)
            begin
               next_pw       = '{{ctrl[1:0], 6'h0, 8'h0, trl_pwr, trl_mer}, 1'b1, KIND_MER};
               next_pw_valid = 1'b1;
               next_state    = S_IDLE;
               done_ev       = 1'b1;
            end
         S_UNIT:
            if (take_unit)
            begin
               // A unit owns the packet until its own last word
               next_pw       = unit;
               next_pw_valid = 1'b1;
               if (unit.last) next_state = S_IDLE;
            end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state    <= S_IDLE;
         sec_left <= 8'h0;
         rem      <= 13'h0;
         idx      <= 2'h0;
         acc      <= 32'h0;
         pw       <= '0;
         pw_valid <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         sec_left <= next_sec_left;
         rem      <= next_rem;
         idx      <= next_idx;
         acc      <= next_acc;
         pw       <= next_pw;
         pw_valid <= next_pw_valid;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trl_pwr <= 8'h0;
         trl_mer <= 8'h0;
      end
      else if (take_rpt)
      begin
         trl_pwr <= rpt.power_err;
         trl_mer <= rpt.burst_mer;
      end
   end

   // Readies are registered; each is raised only when the output slot is free, mer_ready also when its next byte only fills the accumulator
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rpt_ready  <= 1'b0;
         sec_ready  <= 1'b0;
         mer_ready  <= 1'b0;
         unit_ready <= 1'b0;
      end
      else
      begin
         rpt_ready  <= next_state == S_HDR && !next_pw_valid;
         sec_ready  <= next_state == S_SEC && !next_pw_valid;
         mer_ready  <= next_state == S_MER && (!next_pw_valid || (next_idx != 2'h3 && next_rem != 13'h1));
         unit_ready <= next_state == S_UNIT && !next_pw_valid;
      end
   end

   // ----------------------------------------
   // Missed burst handling
   // ----------------------------------------
   slot_s            info;
   logic             in_slot, seen, miss, cnt_we, msg_ev, drop_ev;
   class_s           cls;
   logic [7:0]       ci;
   logic [CNT_W-1:0] cnt [NCNT];
   logic [31:0]      missed;

   assign miss   = slot_end && in_slot && !seen && !preamble && ctrl[CTRL_EN_BIT];
   assign cls    = classify(info);
   assign ci     = cnt_index(info.channel, cls.row, energy_idx(info.energy));
   assign cnt_we = miss && cls.act != ACT_NONE;
   assign msg_ev = miss && cls.act == ACT_MSG;
   assign drop_ev = msg_ev && msg_valid && !msg_ready;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         in_slot <= 1'b0;
         seen    <= 1'b0;
         info    <= '0;
      end
      else if (slot_start)
      begin
         in_slot <= 1'b1;
         seen    <= preamble;
         info    <= slot_info;
      end
      else
      begin
         if (slot_end) in_slot <= 1'b0;
         if (preamble) seen <= 1'b1;
      end
   end

   // Samples pass only once a preamble marks the interval as a real burst
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rf_out_valid <= 1'b0;
         rf_out_data  <= 32'h0;
      end
      else
      begin
         rf_out_valid <= rf_valid && in_slot && (seen || preamble);
         rf_out_data  <= rf_data;
      end
   end

   // Counters saturate rather than wrap so software never sees a false small count
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < NCNT; i++)
            cnt[i] <= '0;
         missed <= 32'h0;
      end
      else if (miss)
      begin
         if (cnt_we && cnt[ci] != '1) cnt[ci] <= cnt[ci] + 16'h1;
         if (missed != 32'hffffffff) missed <= missed + 32'h1;
      end
   end

   // A message still pending loses the newer event, which is flagged
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         msg_valid <= 1'b0;
         msg       <= '0;
      end
      else if (msg_ev && !drop_ev)
      begin
         msg_valid <= 1'b1;
         msg       <= info;
      end
      else if (msg_ready)
         msg_valid <= 1'b0;
   end

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   logic [7:0]      aw_addr, sel;
   logic [31:0]     w_data;
   logic [3:0]      w_strb, mask, events;
   logic [ST_W-1:0] status;
   logic            wr_go;
   logic [7:0]      rsel;

   assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign events = {miss, drop_ev, done_ev, msg_ev};
   assign rsel   = cnt_index(sel[7:6], sel[5:2], sel[1:0]);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr       <= 8'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= (aw_addr == OFS_CTRL || aw_addr == OFS_STATUS || aw_addr == OFS_MASK
                              || aw_addr == OFS_SEL) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl <= CTRL_RST;
         mask <= MASK_RST;
         sel  <= 8'h0;
      end
      else if (wr_go)
      begin
         if (aw_addr == OFS_CTRL) ctrl <= 3'(strb({29'h0, ctrl}, w_data, w_strb));
         if (aw_addr == OFS_MASK) mask <= 4'(strb({28'h0, mask}, w_data, w_strb));
         if (aw_addr == OFS_SEL)  sel  <= 8'(strb({24'h0, sel}, w_data, w_strb));
      end
   end

   // Hardware set wins over a same-cycle clear
   always_ff @(posedge clk)
   begin
      if (reset)
         status <= '0;
      else if (wr_go && aw_addr == OFS_STATUS && w_strb[0])
         status <= (status & ~w_data[ST_W-1:0]) | events;
      else
         status <= status | events;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(status & mask);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL:   s_axi_rdata <= {29'h0, ctrl};
            OFS_STATUS: s_axi_rdata <= {28'h0, status};
            OFS_MASK:   s_axi_rdata <= {28'h0, mask};
            OFS_SEL:    s_axi_rdata <= {24'h0, sel};
            OFS_COUNT:  s_axi_rdata <= (sel[5:2] < ROWS && sel[1:0] != 2'h3) ? {16'h0, cnt[rsel]} : 32'h0;
            OFS_MISSED: s_axi_rdata <= missed;
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_hdr_count: assert property (take_rpt |=> pw_valid && pw.data[7:0] == $past(rpt.sections))
      else $error("header count wrong");
   a_sec_low: assert property (take_sec |=> pw.data[31:28] == 4'h0 && pw.data[27:16] == $past(sec.lowest))
      else $error("section lowest field wrong");
   a_sec_high: assert property (take_sec |=> pw.data[15:12] == 4'h0 && pw.data[11:0] == $past(sec.highest))
      else $error("section highest field wrong");
   a_mer_first: assert property (take_mer && idx == 2'h0 && rem == 13'h1 |=> pw.data[31:24] == $past(mer_byte))
      else $error("value byte misplaced");
   a_mer_pad: assert property (take_mer && idx == 2'h0 && rem == 13'h1 |=> pw.data[23:0] == 24'h0)
      else $error("padding not zero");
   a_trl_status: assert property (pw_valid && pw.last && pw.kind == KIND_MER |-> pw.data[29:16] == 14'h0)
      else $error("trailer reserved bits set");
   a_trl_power: assert property (pw_valid && pw.last && pw.kind == KIND_MER |-> pw.data[15:8] == trl_pwr)
      else $error("trailer power error wrong");
   a_trl_mer: assert property (pw_valid && pw.last && pw.kind == KIND_MER |-> pw.data[7:0] == trl_mer)
      else $error("trailer burst ratio wrong");
   a_unit_pass: assert property (take_unit |=> pw_valid && pw == $past(unit))
      else $error("unit word altered");
   a_unit_alone: assert property (unit_ready |-> state == S_UNIT && !pw_valid)
      else $error("unit mixed into other traffic");
   a_miss_count: assert property (miss && missed != 32'hffffffff |=> missed == $past(missed) + 32'h1)
      else $error("missed burst not recorded");
   a_rf_drop: assert property (rf_out_valid |-> $past(in_slot && (seen || preamble)))
      else $error("missed burst content forwarded");
   a_msg_raise: assert property (msg_ev && !msg_valid |=> msg_valid && msg == $past(info))
      else $error("core message not raised");
   a_no_action: assert property (miss && (info.interval_usage_code == 4'h7 || info.interval_usage_code >= 4'hc) |-> !cnt_we && !msg_ev)
      else $error("ignored code acted upon");
   a_rows_count: assert property (miss && info.interval_usage_code inside {[4'h1:4'h4]} && info.energy != 2'h3 |-> cnt_we && !msg_ev)
      else $error("request code not counted");

   c_report: cover property (take_sec ##[1:20] (pw_valid && pw.last && pw.kind == KIND_MER));
   c_unit: cover property (take_unit && unit.last && unit.kind == KIND_IMP);
   c_msg: cover property (msg_valid && msg_ready);
endmodule

`default_nettype wire

/* pkg/mer_pkg.sv */
// Shared constants and carriers for the modulation error report framer.
// Assumes one 50 MHz clock domain and AXI4-Lite register access.
package mer_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_STATUS = 8'h04;
   localparam logic [7:0]  OFS_MASK   = 8'h08;
   localparam logic [7:0]  OFS_SEL    = 8'h0c;
   localparam logic [7:0]  OFS_COUNT  = 8'h10;
   localparam logic [7:0]  OFS_MISSED = 8'h14;
   // Control fields and reset
   localparam int          CTRL_EN_BIT = 2;
   localparam logic [2:0]  CTRL_RST    = 3'h4;
   // Status bits
   localparam int          ST_MSG  = 0;
   localparam int          ST_DONE = 1;
   localparam int          ST_DROP = 2;
   localparam int          ST_MISS = 3;
   localparam int          ST_W    = 4;
   localparam logic [3:0]  MASK_RST = 4'h0;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // Energy classes and broadcast identifier
   localparam logic [1:0]  EN_LOW  = 2'h1;
   localparam logic [1:0]  EN_MED  = 2'h0;
   localparam logic [1:0]  EN_HIGH = 2'h2;
   localparam logic [13:0] BCAST_SID = 14'h3fff;
   // Counter table layout
   localparam logic [3:0]  NO_ROW     = 4'hf;
   localparam logic [3:0]  ROWS       = 4'hb;
   localparam logic [7:0]  CNT_PER_CH = 8'h21;
   localparam logic [7:0]  EN_SLOTS   = 8'h03;
   localparam int          NCNT       = 132;
   localparam int          CNT_W      = 16;
   // Unit kinds on the pseudowire
   localparam logic [1:0]  KIND_MER = 2'h0;
   localparam logic [1:0]  KIND_IMP = 2'h1;
   localparam logic [1:0]  KIND_TSA = 2'h2;

   typedef enum logic [1:0] {ACT_NONE, ACT_COUNT, ACT_MSG} act_e;
   typedef struct packed {act_e act; logic [3:0] row;} class_s;
   typedef struct packed {logic [31:0] data; logic last; logic [1:0] kind;} pw_s;
   typedef struct packed {logic [7:0] sections; logic [7:0] power_err; logic [7:0] burst_mer;} rpt_s;
   typedef struct packed {logic [11:0] lowest; logic [11:0] highest;} sec_s;
   typedef struct packed {logic [3:0] interval_usage_code; logic [13:0] service_identifier; logic [1:0] energy; logic [1:0] channel;} slot_s;
endpackage

/* sim/core_sink.sv */
// Core model: sinks pseudowire words, counts messages.
// Assumes the framer on clk; stalls now and then.
`timescale 1ns/1ps
`default_nettype none
module core_sink (
   // Clock and streams
   input  wire logic         clk,
   input  wire logic         pw_valid,
   input  wire mer_pkg::pw_s pw,
   output logic              pw_ready,
   input  wire logic         msg_valid,
   output logic              msg_ready
);
   import mer_pkg::*;
   logic [34:0] words[$];
   int          n_msg = 0;
   logic [2:0]  st = 3'h0;
   // Periodic stalls so held words are seen
   assign pw_ready  = st != 3'h2;
   assign msg_ready = st[0];
   always @(posedge clk)
   begin
      st <= st + 3'h1;
      if (pw_valid && pw_ready)
         words.push_back({pw.kind, pw.last, pw.data});
      if (msg_valid && msg_ready)
         n_msg++;
   end
endmodule
`default_nettype wire

/* sim/upstream_mer_report_and_no_burst_handler_tb.sv */
// Bench: report framing, missed bursts, registers.
// Assumes mer_pkg and core_sink compiled first.
`timescale 1ns/1ps
`default_nettype none
module upstream_mer_report_and_no_burst_handler_tb;
   import mer_pkg::*;
   logic        clk = 1'h0, reset = 1'h1;
   logic        av = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, rv = 1'h0, sv = 1'h0;
   logic        mv = 1'h0, ss = 1'h0, pre = 1'h0, se = 1'h0, rfv = 1'h0, uv = 1'h0;
   logic [7:0]  aa = 8'h0, mb = 8'h0;
   logic [11:0] lo, hi;
   logic [31:0] wd = 32'h0, rfd = 32'h0, lf = 32'h5136, rd, v, t, u, w, ro, rfl;
   rpt_s        rpt = '0;
   sec_s        sec = '0;
   slot_s       si = '0, mg;
   pw_s         pw, un = '0;
   logic        awr, wrr, bv, arr, rvl, rpr, scr, mr, pwv, pwr, rfo, msv, msr, irq, unr;
   logic [1:0]  bresp, rresp, rs;
   logic [34:0] eq[$];
   int          fails = 0, n_checks = 0, rfn = 0, r0, n;
   mer_report_framer mer_report_framer_inst (.clk(clk), .reset(reset), .s_axi_awaddr(aa), .s_axi_awvalid(av),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(aa), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr),
      .rpt_valid(rv), .rpt(rpt), .rpt_ready(rpr), .sec_valid(sv), .sec(sec), .sec_ready(scr), .mer_valid(mv),
      .mer_byte(mb), .mer_ready(mr), .unit_valid(uv), .unit(un), .unit_ready(unr), .pw_valid(pwv), .pw(pw),
      .pw_ready(pwr), .slot_start(ss), .slot_info(si), .preamble(pre), .slot_end(se), .rf_valid(rfv),
      .rf_data(rfd), .rf_out_valid(rfo), .rf_out_data(ro), .msg_valid(msv), .msg(mg), .msg_ready(msr), .irq(irq));
   core_sink core_sink_inst (.clk(clk), .pw_valid(pwv), .pw(pw), .pw_ready(pwr), .msg_valid(msv),
      .msg_ready(msr));
   initial forever #10 clk = ~clk;
   always @(posedge clk)
   begin
      rfn <= rfn + int'(rfo);
      if (rfo) rfl <= ro;
   end
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction
   task automatic chk(input string s, input logic [34:0] e, input logic [34:0] g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   // Bus tasks release each channel only at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      aa <= a; wd <= d; av <= 1'h1; wv <= 1'h1; br <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awr) av <= 1'h0;
         if (wrr) wv <= 1'h0;
      end
      while (!bv);
      rs = bresp;
      br <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rdr(input logic [7:0] a);
      aa <= a; arv <= 1'h1; rr <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end
      while (!rvl);
      v = rd;
      rs = rresp;
      rr <= 1'h0;
      @(posedge clk);
   endtask
   task automatic hs(input int k);
      do @(posedge clk); while (!(k == 0 ? rpr : k == 1 ? scr : k == 2 ? mr : unr));
   endtask
   task automatic slot(input logic [3:0] c, input logic [13:0] id, input logic [1:0] e, input logic p);
      ss <= 1'h1; si <= {c, id, e, 2'h0}; rfv <= 1'h1; rfd <= rnd();
      @(posedge clk);
      ss <= 1'h0; se <= 1'h1; pre <= p;
      @(posedge clk);
      se <= 1'h0; pre <= 1'h0; rfv <= 1'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic cnt(input logic [7:0] s, input logic [31:0] e);
      wr(OFS_SEL, {24'h0, s});
      rdr(OFS_COUNT);
      chk("count", e, v);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      rdr(OFS_CTRL);
      chk("ctrl", 32'h4, v);
      rdr(OFS_MASK);
      chk("mask", 32'h0, v);
      rdr(8'h40);
      chk("unmapped", RESP_SLVERR, rs);
      wr(OFS_MISSED, 32'h5);
      chk("ro write", RESP_SLVERR, rs);
      // Version 1 with detection left on, so header and trailer carry a nonzero version
      wr(OFS_CTRL, 32'h5);
      $display("regs done");
      t = rnd();
      rpt <= {8'h2, t[15:0]}; rv <= 1'h1;
      hs(0);
      rv <= 1'h0;
      eq.push_back({2'h1, 22'h0, 8'h2});
      for (int s = 0; s < 2; s++)
      begin
         u = rnd();
         n = int'(u[14:12]) % 6 + 1;
         lo = {1'h0, u[10:0]};
         hi = lo + 12'(n - 1);
         sec <= {lo, hi}; sv <= 1'h1;
         hs(1);
         sv <= 1'h0;
         eq.push_back({5'h0, lo, 4'h0, hi});
         w = 32'h0;
         for (int j = 0; j < n; j++)
         begin
            u = rnd();
            mb <= u[7:0]; mv <= 1'h1;
            hs(2);
            w[31 - 8 * (j % 4) -: 8] = u[7:0];
            if (j % 4 == 3 || j == n - 1)
            begin
               eq.push_back({1'h0, w});
               w = 32'h0;
            end
         end
         mv <= 1'h0;
      end
      eq.push_back({1'h1, 2'h1, 14'h0, t[15:0]});
      // Two impulse words then one spectrum word; offered early, they must wait for the trailer
      for (int k = 0; k < 3; k++)
      begin
         u = rnd();
         un <= {u, 1'(k != 0), (k < 2) ? KIND_IMP : KIND_TSA}; uv <= 1'h1;
         hs(3);
         eq.push_back({((k < 2) ? KIND_IMP : KIND_TSA), 1'(k != 0), u});
      end
      uv <= 1'h0;
      for (int i = 0; i < 400 && core_sink_inst.words.size() < eq.size(); i++) @(posedge clk);
      chk("words", eq.size(), core_sink_inst.words.size());
      foreach (eq[i]) chk("word", eq[i], core_sink_inst.words[i]);
      $display("report done");
      r0 = rfn;
      for (int i = 1; i < 16; i++) slot(4'(i), 14'h0123, EN_LOW, 1'h0);
      chk("msgs", 5, core_sink_inst.n_msg);
      chk("msg", {4'hb, 14'h0123, EN_LOW, 2'h0}, mg);
      slot(4'h1, BCAST_SID, EN_HIGH, 1'h0);
      slot(4'h1, BCAST_SID, EN_HIGH, 1'h0);
      slot(4'h4, 14'h0007, EN_MED, 1'h0);
      chk("rf drop", r0, rfn);
      slot(4'h2, 14'h0007, EN_MED, 1'h1);
      chk("rf pass", 1'h1, rfn > r0);
      chk("rf data", rfd, rfl);
      // Detection off: this empty interval must not add to the total
      wr(OFS_CTRL, 32'h1);
      slot(4'h2, 14'h0007, EN_MED, 1'h0);
      rdr(OFS_MISSED);
      chk("missed", 32'd18, v);
      cnt(8'h02, 32'h2);
      cnt(8'h04, 32'h1);
      cnt(8'h15, 32'h1);
      wr(OFS_MASK, 32'h8);
      chk("irq on", 1'h1, irq);
      wr(OFS_STATUS, 32'h8);
      chk("irq off", 1'h0, irq);
      $display("missed done");
      print_verdict;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict;
   end
   task automatic print_verdict;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
endmodule
`default_nettype wire
